//--- dv/rx_ctl_asserts.sv
// Pin-level checks for the receiver control block.
// Assumes it is bound to the top module; pins settle three edges after a change.
`timescale 1ns/1ps
module rx_ctl_asserts #(
  parameter int BIT_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins
  input wire logic enable_n_in,
  input wire logic charge_done_in,
  input wire logic die_hot_in,
  input wire logic remote_temp_a_in,
  input wire logic remote_temp_b_in,
  input wire logic out_level_select_gnd_in,
  input wire logic overcurrent_select_gnd_in,
  // Outputs
  input wire logic coil_node_a_load_out,
  input wire logic coil_node_b_load_out,
  input wire logic fault_n_out,
  input wire logic fault_oe_out,
  input wire logic link_up_led_n_out,
  input wire logic link_up_led_oe_out,
  input wire logic out_hiz_out,
  input wire logic current_limit_en_out,
  input wire logic [wrx_pkg::VOUT_CODE_W-1:0] out_level_code_out
);
  import wrx_pkg::*;
  logic src, load_q;
  int run_q;
  assign src = enable_n_in | charge_done_in | die_hot_in | remote_temp_a_in | remote_temp_b_in;
  // Length of the current load level, read at each change that ends a load-on level
  always_ff @(posedge clk_in) begin
    load_q <= coil_node_a_load_out;
    if (rst_in || coil_node_a_load_out != load_q) run_q <= 1;
    else run_q <= run_q + 1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence fault_held;
    src [*4];
  endsequence
  sequence calm_held;
    !src [*4];
  endsequence
  AST_FAULT_SET: assert property (fault_held |-> fault_oe_out)
    else $error("fault flag not pulled");
  AST_FAULT_CLEAR: assert property (calm_held |-> !fault_oe_out)
    else $error("fault flag not released");
  AST_SHUTDOWN: assert property ($rose(enable_n_in) |-> ##[1:5]
    (!link_up_led_oe_out && out_hiz_out)) else $error("shutdown not entered");
  AST_LED_HIZ: assert property (link_up_led_oe_out |-> !out_hiz_out)
    else $error("link shown while output off");
  AST_OD_LOW: assert property (!fault_n_out && !link_up_led_n_out)
    else $error("open-drain data not low");
  AST_LEVEL: assert property (out_level_select_gnd_in [*4] |->
    out_level_code_out == VOUT_CODE_5V) else $error("grounded select not default level");
  AST_CLIMIT: assert property (overcurrent_select_gnd_in [*4] |-> !current_limit_en_out)
    else $error("current limit still on");
  AST_LOADS: assert property (coil_node_a_load_out == coil_node_b_load_out)
    else $error("coil loads differ");
  AST_BIT_LEN: assert property ((coil_node_a_load_out != load_q) && load_q |->
    run_q % BIT_CYCLES == 0) else $error("load pulse not whole bits");
endmodule

//--- dv/testbench.sv
// Self-checking bench for the receiver control block with a transmitter model.
// Assumes a 25 MHz clock and a shortened bit period.
`timescale 1ns/1ps
module testbench;
  import wrx_pkg::*;
  localparam int BC = 20;
  logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, rd_d = 1'b0;
  logic [ADDR_W-1:0] addr_in = 4'h0;
  logic [DATA_W-1:0] wdata_in = 16'h0, rdata_out;
  logic enable_n_in = 1'b0, charge_done_in = 1'b0, die_hot_in = 1'b0, power_ok_in = 1'b0;
  logic remote_temp_a_in = 1'b0, remote_temp_b_in = 1'b0;
  logic out_level_select_gnd_in = 1'b0, overcurrent_select_gnd_in = 1'b0;
  logic [VOUT_CODE_W-1:0] out_level_sense_in = 3'h5, out_level_code_out;
  logic irq_out, coil_node_a_load_out, coil_node_b_load_out, fault_n_out, fault_oe_out;
  logic link_up_led_n_out, link_up_led_oe_out, out_hiz_out, current_limit_en_out, pv, ferr;
  logic [PKT_W-1:0] got;
  logic [PKT_W-1:0] pkt_q[$];
  logic [DATA_W-1:0] rd_q[$];
  int miscompares = 0, samples_checked = 0, npkt = 0;
  wireless_rx_power_control #(.BIT_CYCLES(BC)) uut (.clk_in, .rst_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .irq_out, .enable_n_in, .charge_done_in, .die_hot_in,
    .remote_temp_a_in, .remote_temp_b_in, .power_ok_in, .out_level_select_gnd_in,
    .overcurrent_select_gnd_in, .out_level_sense_in, .coil_node_a_load_out,
    .coil_node_b_load_out, .fault_n_out, .fault_oe_out, .link_up_led_n_out,
    .link_up_led_oe_out, .out_hiz_out, .current_limit_en_out, .out_level_code_out);
  tx_demod #(.BIT_CYCLES(BC)) tx (.clk_in, .rst_in, .load_in(coil_node_a_load_out),
    .pkt_valid_out(pv), .pkt_out(got), .frame_err_out(ferr));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk(input logic [PKT_W-1:0] seen, input logic [PKT_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    chk(ferr, 1'b0);
    chk(24'(pkt_q.size()), 24'h0);
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // A spare edge after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd_q.push_back(e);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic pk(input logic [7:0] h, input logic [7:0] p);
    pkt_q.push_back({h, p, h ^ p});
  endtask
  task automatic wait_pkts(input int n);
    for (int k = 0; k < 4000 && npkt < n; k++) @(posedge clk_in);
    if (npkt < n) miscompares++;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    rd_d <= rd_in;
    if (rd_d) chk(rdata_out, rd_q.pop_front());
    if (pv) begin
      npkt++;
      chk(got, pkt_q.size() ? pkt_q.pop_front() : 'x);
    end
  end
  initial begin
    wait_cyc(40000);
    miscompares++;
    end_sim();
  end
  initial begin
    logic [3:0] s;
    logic [7:0] r;
    void'($urandom(32'h24ed));
    wait_cyc(6);
    rst_in <= 1'b0;
    wait_cyc(1);
    chk({out_hiz_out, current_limit_en_out, out_level_code_out}, {2'b11, VOUT_CODE_5V});
    rd(REG_CTRL, 16'h0010);
    rd(REG_STRENGTH, 16'h0080);
    rd(4'hf, 16'h0);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0);
    wr(REG_IRQ_MASK, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      {die_hot_in, remote_temp_a_in, remote_temp_b_in, charge_done_in, enable_n_in} <= 5'h1 << i;
      wait_cyc(5);
      chk(fault_oe_out, 1'b1);
      {die_hot_in, remote_temp_a_in, remote_temp_b_in, charge_done_in, enable_n_in} <= 5'h0;
      wait_cyc(5);
      chk(fault_oe_out, 1'b0);
    end
    chk(irq_out, 1'b1);
    rd(REG_IRQ_STAT, 16'h0001);
    wr(REG_IRQ_STAT, 16'h0001);
    wait_cyc(2);
    chk(irq_out, 1'b0);
    for (int j = 0; j < 2; j++) begin
      if (j == 1) begin
        wr(REG_STRENGTH, {8'h0, ~r});
        wr(REG_CONFIG, {8'h0, r});
        rd(REG_CONFIG, {8'h0, r});
      end
      pk(HDR_STRENGTH, j ? ~r : STRENGTH_RST);
      pk(HDR_IDENT, 8'h5a);
      pk(HDR_CONFIG, j ? r : CONFIG_RST);
      pk(HDR_CTRL_ERR, 8'h0);
      if (j == 1) pk(HDR_EPT, EPT_CHARGE_DONE);
      enable_n_in <= 1'b0;
      power_ok_in <= 1'b1;
      wait_pkts(3 + 7 * j);
      wait_cyc(20);
      chk({link_up_led_oe_out, out_hiz_out}, 2'b10);
      if (j == 0) begin
        r = 8'($urandom);
        out_level_sense_in <= r[2:0];
        wait_cyc(5);
        chk({out_level_code_out, current_limit_en_out}, {r[2:0], 1'b1});
        out_level_select_gnd_in <= 1'b1;
        overcurrent_select_gnd_in <= 1'b1;
        wait_cyc(5);
        chk({out_level_code_out, current_limit_en_out}, {VOUT_CODE_5V, 1'b0});
        wait_pkts(4);
        s = 4'($urandom_range(15, 1));
        wr(REG_CTRL, {8'h0, s, 2'b00, CMD_UP});
        pk(HDR_CTRL_ERR, {4'h0, s});
        wait_pkts(5);
        wr(REG_CTRL, {8'h0, s, 2'b00, CMD_DOWN});
        pk(HDR_CTRL_ERR, 8'h0 - {4'h0, s});
        wait_pkts(6);
        wr(REG_CTRL, {r, s, 2'b00, CMD_END});
        pk(HDR_EPT, r);
        wait_pkts(7);
      end else begin
        wait_cyc(100);
        charge_done_in <= 1'b1;
        wait_pkts(12);
      end
      wait_cyc(20);
      chk({link_up_led_oe_out, out_hiz_out}, 2'b01);
      wr(REG_CTRL, 16'h0010);
      enable_n_in <= 1'b1;
      wait_cyc(5);
      chk({fault_oe_out, out_hiz_out}, 2'b11);
    end
    charge_done_in <= 1'b0;
    wait_cyc(5);
    chk(fault_oe_out, 1'b1);
    rd(REG_IRQ_STAT, 16'h0007);
    wait_cyc(1);
    end_sim();
  end
endmodule
bind wireless_rx_power_control rx_ctl_asserts #(.BIT_CYCLES(BIT_CYCLES)) ast (.clk_in, .rst_in,
  .enable_n_in, .charge_done_in, .die_hot_in, .remote_temp_a_in, .remote_temp_b_in,
  .out_level_select_gnd_in, .overcurrent_select_gnd_in, .coil_node_a_load_out,
  .coil_node_b_load_out, .fault_n_out, .fault_oe_out, .link_up_led_n_out,
  .link_up_led_oe_out, .out_hiz_out, .current_limit_en_out, .out_level_code_out);

//--- dv/tx_demod.sv
// Transmitter-side model: turns coil load changes back into packets.
// Assumes load on is a zero bit, idle load off, 11-bit frames sent LSB first.
`timescale 1ns/1ps
module tx_demod #(
  parameter int BIT_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Coil load as the transmitter sees it
  input wire logic load_in,
  // Decoded packets
  output logic pkt_valid_out,
  output logic [23:0] pkt_out,
  output logic frame_err_out
);
  logic busy, prev;
  logic [10:0] f;
  int cnt, nbit, nbyte;
  always @(posedge clk_in) begin
    pkt_valid_out <= 1'b0;
    prev <= load_in;
    if (rst_in) begin
      busy <= 1'b0;
      nbyte <= 0;
      frame_err_out <= 1'b0;
    end else if (!busy) begin
      // Half a bit first so every later sample lands mid-bit
      if (load_in && !prev) begin
        busy <= 1'b1;
        cnt <= BIT_CYCLES / 2;
        nbit <= 0;
      end
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      f = {~load_in, f[10:1]};
      cnt <= BIT_CYCLES;
      nbit <= nbit + 1;
      if (nbit == 10) begin
        busy <= 1'b0;
        if (f[0] || !f[10] || !(^f[9:1])) frame_err_out <= 1'b1;
        pkt_out <= {pkt_out[15:0], f[8:1]};
        nbyte <= (nbyte == 2) ? 0 : nbyte + 1;
        pkt_valid_out <= (nbyte == 2);
      end
    end
  end
endmodule

//--- verilog/rx_load_modulator.sv
// Serialises one packet onto the coil load switches, one bit per bit period.
// Assumes start_in is a single-cycle pulse given only while busy_out is low.
`timescale 1ns/1ps
module rx_load_modulator #(
  parameter int BIT_CYCLES = wrx_pkg::BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Packet request
  input wire logic start_in,
  input wire logic [wrx_pkg::PKT_W-1:0] packet_in,
  output logic busy_out,
  output logic done_out,
  // Load switch drive
  output logic load_on_out
);
  import wrx_pkg::*;

  localparam int CW = $clog2(BIT_CYCLES);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [3:0] bits_left;
    logic [1:0] bytes_left;
    logic [FRAME_BITS-1:0] frame;
    logic [PKT_W-1:0] pkt;
    logic busy;
    logic done;
    logic load;
  } mod_state_t;

  mod_state_t q, d;

  // Start bit, data LSB first, odd parity, stop bit
  function automatic logic [FRAME_BITS-1:0] make_frame(input logic [7:0] b);
    make_frame = {1'b1, ~^b, b, 1'b0};
  endfunction

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!q.busy) begin
      if (start_in) begin
        d.busy = 1'b1;
        d.cnt = '0;
        d.frame = make_frame(packet_in[PKT_W-1 -: 8]);
        d.pkt = packet_in << 8;
        d.bits_left = 4'(FRAME_BITS - 1);
        d.bytes_left = 2'(PKT_BYTES - 1);
        d.load = ~d.frame[0];
      end
    end else if (q.cnt == CW'(BIT_CYCLES - 1)) begin
      d.cnt = '0;
      if (q.bits_left != 4'h0) begin
        d.frame = q.frame >> 1;
        d.bits_left = q.bits_left - 4'h1;
        d.load = ~d.frame[0];
      end else if (q.bytes_left != 2'h0) begin
        d.frame = make_frame(q.pkt[PKT_W-1 -: 8]);
        d.pkt = q.pkt << 8;
        d.bytes_left = q.bytes_left - 2'h1;
        d.bits_left = 4'(FRAME_BITS - 1);
        d.load = ~d.frame[0];
      end else begin
        // Load released between packets so the coil idles unloaded
        d.busy = 1'b0;
        d.done = 1'b1;
        d.load = 1'b0;
      end
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy_out = q.busy;
  assign done_out = q.done;
  assign load_on_out = q.load;

endmodule

//--- verilog/wireless_rx_power_control.sv
// Receiver control: start-up handshake, power control packets, fault and link pins.
// Assumes pins are asynchronous levels; register port is on clk_in.
`timescale 1ns/1ps
module wireless_rx_power_control #(
  parameter int BIT_CYCLES = wrx_pkg::BIT_CYCLES,
  // Identification payload; value is arbitrary
  parameter logic [7:0] ID_CODE = 8'h5a
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [wrx_pkg::ADDR_W-1:0] addr_in,
  input wire logic [wrx_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [wrx_pkg::DATA_W-1:0] rdata_out,
  output logic irq_out,
  // Control pins
  input wire logic enable_n_in,
  input wire logic charge_done_in,
  input wire logic die_hot_in,
  input wire logic remote_temp_a_in,
  input wire logic remote_temp_b_in,
  input wire logic power_ok_in,
  // Programming selections
  input wire logic out_level_select_gnd_in,
  input wire logic overcurrent_select_gnd_in,
  input wire logic [wrx_pkg::VOUT_CODE_W-1:0] out_level_sense_in,
  // Coil load switches
  output logic coil_node_a_load_out,
  output logic coil_node_b_load_out,
  // Open-drain flags
  output logic fault_n_out,
  output logic fault_oe_out,
  output logic link_up_led_n_out,
  output logic link_up_led_oe_out,
  // Output stage
  output logic out_hiz_out,
  output logic current_limit_en_out,
  output logic [wrx_pkg::VOUT_CODE_W-1:0] out_level_code_out
);
  import wrx_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [VOUT_CODE_W-1:0] lvl_s1;
    logic [VOUT_CODE_W-1:0] lvl_s2;
    logic done_prev;
    rx_state_t state;
    power_cmd_t cmd;
    logic [STEP_W-1:0] step;
    logic [7:0] sw_reason;
    logic [7:0] strength;
    logic [7:0] config_byte;
    logic ept_req;
    logic [7:0] ept_reason;
    logic start;
    logic [PKT_W-1:0] pkt;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [DATA_W-1:0] rdata;
    logic fault_oe;
    logic led_oe;
    logic out_hiz;
    logic cur_lim_en;
    logic [VOUT_CODE_W-1:0] vout_code;
  } ctrl_state_t;

  ctrl_state_t q, d;

  logic ser_busy;
  logic ser_done;
  logic ser_load;

  function automatic logic [PKT_W-1:0] build_pkt(input logic [7:0] hdr,
                                                 input logic [7:0] payload);
    build_pkt = {hdr, payload, hdr ^ payload};
  endfunction

  // Signed control error: positive asks for more power
  function automatic logic [7:0] ctrl_error(input power_cmd_t cmd,
                                            input logic [STEP_W-1:0] step);
    case (cmd)
      CMD_UP: ctrl_error = {4'h0, step};
      CMD_DOWN: ctrl_error = 8'h00 - {4'h0, step};
      default: ctrl_error = 8'h00;
    endcase
  endfunction

  function automatic logic handshaking(input rx_state_t s);
    handshaking = (s == ST_SS) || (s == ST_ID) || (s == ST_CFG) || (s == ST_XFER);
  endfunction

  // One packet at a time: starts go out only once the serialiser is idle or just done
  rx_load_modulator #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_mod (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(q.start),
    .packet_in(q.pkt),
    .busy_out(ser_busy),
    .done_out(ser_done),
    .load_on_out(ser_load)
  );

  logic en_n;
  logic chg_done;
  logic pwr_ok;
  logic fault_now;
  logic [IRQ_W-1:0] ev;

  always_comb begin
    d = q;
    d.start = 1'b0;
    ev = '0;
    // Two-stage synchronisers; only the second stage is looked at
    d.pin_s1 = {overcurrent_select_gnd_in, out_level_select_gnd_in, power_ok_in,
                remote_temp_b_in, remote_temp_a_in, die_hot_in, charge_done_in,
                enable_n_in};
    d.pin_s2 = q.pin_s1;
    d.lvl_s1 = out_level_sense_in;
    d.lvl_s2 = q.lvl_s1;
    en_n = q.pin_s2[PIN_EN_N];
    chg_done = q.pin_s2[PIN_DONE];
    pwr_ok = q.pin_s2[PIN_PWR_OK];
    d.done_prev = chg_done;

    // Flag follows its causes both ways, so it releases with the last one
    fault_now = en_n | chg_done | q.pin_s2[PIN_DIE_HOT] | q.pin_s2[PIN_TEMP_A]
                | q.pin_s2[PIN_TEMP_B];
    d.fault_oe = fault_now;
    ev[IRQ_FAULT] = fault_now & ~q.fault_oe;

    if (chg_done && !q.done_prev && handshaking(q.state)) begin
      d.ept_req = 1'b1;
      d.ept_reason = EPT_CHARGE_DONE;
    end

    // An end request waits for the packet on the coil; a cut packet would be dropped
    if (ser_done && q.ept_req && handshaking(q.state)) begin
      d.pkt = build_pkt(HDR_EPT, q.ept_reason);
      d.start = 1'b1;
      d.state = ST_EPT;
    end else begin
      case (q.state)
        ST_OFF: begin
          if (!en_n) begin
            d.state = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (pwr_ok && !ser_busy) begin
            d.pkt = build_pkt(HDR_STRENGTH, q.strength);
            d.start = 1'b1;
            d.state = ST_SS;
          end
        end
        ST_SS: begin
          if (ser_done) begin
            d.pkt = build_pkt(HDR_IDENT, ID_CODE);
            d.start = 1'b1;
            d.state = ST_ID;
          end
        end
        ST_ID: begin
          if (ser_done) begin
            d.pkt = build_pkt(HDR_CONFIG, q.config_byte);
            d.start = 1'b1;
            d.state = ST_CFG;
          end
        end
        ST_CFG, ST_XFER: begin
          if (ser_done) begin
            // Back to back so the transmitter never runs unattended
            d.pkt = build_pkt(HDR_CTRL_ERR, ctrl_error(q.cmd, q.step));
            d.start = 1'b1;
            d.state = ST_XFER;
            ev[IRQ_LINK] = (q.state == ST_CFG);
          end
        end
        ST_EPT: begin
          if (ser_done) begin
            d.state = ST_DONE;
            d.ept_req = 1'b0;
            ev[IRQ_EPT] = 1'b1;
          end
        end
        ST_DONE: begin
          // Stays off with the output released until the enable pin cycles
          d.state = ST_DONE;
        end
        default: begin
          d.state = ST_OFF;
        end
      endcase
    end

    if (en_n) begin
      d.state = ST_OFF;
      d.ept_req = 1'b0;
      d.start = 1'b0;
    end else if (!pwr_ok && (handshaking(q.state) || q.state == ST_EPT)) begin
      // Losing the rectifier mid-exchange restarts from the ping
      d.state = ST_WAIT;
      d.ept_req = 1'b0;
      d.start = 1'b0;
      ev[IRQ_LOST] = 1'b1;
    end

    d.led_oe = (d.state == ST_XFER);
    d.out_hiz = (d.state != ST_XFER);
    // Selection pins are watched all the time; a change shows three edges later
    d.cur_lim_en = ~q.pin_s2[PIN_IOC_GND];
    d.vout_code = q.pin_s2[PIN_OUT_LEVEL_SELECT_GND] ? VOUT_CODE_5V : q.lvl_s2;

    if (wr_in) begin
      case (addr_in)
        REG_CTRL: begin
          d.cmd = power_cmd_t'(wdata_in[CTRL_CMD_LSB +: CMD_W]);
          d.step = wdata_in[CTRL_STEP_LSB +: STEP_W];
          d.sw_reason = wdata_in[CTRL_REASON_LSB +: 8];
          // Judged on the next state so a shutdown or power loss in this cycle
          // cannot leave a stale request behind for the next start-up
          if (power_cmd_t'(wdata_in[CTRL_CMD_LSB +: CMD_W]) == CMD_END &&
              handshaking(d.state) && !d.ept_req) begin
            d.ept_req = 1'b1;
            d.ept_reason = wdata_in[CTRL_REASON_LSB +: 8];
          end
        end
        REG_IRQ_MASK: d.irq_mask = wdata_in[IRQ_W-1:0];
        REG_STRENGTH: d.strength = wdata_in[7:0];
        REG_CONFIG: d.config_byte = wdata_in[7:0];
        default: d.irq_mask = q.irq_mask;
      endcase
    end
    // New events win over a write-one-to-clear in the same cycle
    if (wr_in && addr_in == REG_IRQ_STAT) begin
      d.irq_stat = (q.irq_stat & ~wdata_in[IRQ_W-1:0]) | ev;
    end else begin
      d.irq_stat = q.irq_stat | ev;
    end
    // Taken from the next status so a clear drops the line right after the write
    d.irq = |(d.irq_stat & d.irq_mask);

    // Read data stands one cycle only and is zero otherwise
    d.rdata = '0;
    if (rd_in) begin
      case (addr_in)
        REG_CTRL: d.rdata = {q.sw_reason, q.step, 2'h0, q.cmd};
        REG_STATUS: begin
          d.rdata[PIN_W-1:0] = q.pin_s2;
          d.rdata[STAT_STATE_LSB +: 3] = q.state;
          d.rdata[STAT_BUSY_BIT] = ser_busy;
          d.rdata[STAT_EPT_BIT] = q.ept_req;
          d.rdata[STAT_FAULT_BIT] = q.fault_oe;
        end
        REG_IRQ_STAT: d.rdata[IRQ_W-1:0] = q.irq_stat;
        REG_IRQ_MASK: d.rdata[IRQ_W-1:0] = q.irq_mask;
        REG_STRENGTH: d.rdata[7:0] = q.strength;
        REG_CONFIG: d.rdata[7:0] = q.config_byte;
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
      q.state <= ST_OFF;
      q.cmd <= CMD_HOLD;
      q.step <= STEP_RST;
      q.strength <= STRENGTH_RST;
      q.config_byte <= CONFIG_RST;
      q.out_hiz <= 1'b1;
      q.cur_lim_en <= 1'b1;
      q.vout_code <= VOUT_CODE_5V;
      // Level stages start at the default code so the output never dips at release
      q.lvl_s1 <= VOUT_CODE_5V;
      q.lvl_s2 <= VOUT_CODE_5V;
    end else begin
      q <= d;
    end
  end

  assign rdata_out = q.rdata;
  assign irq_out = q.irq;
  // Both coil nodes switch together for AC modulation
  assign coil_node_a_load_out = ser_load;
  assign coil_node_b_load_out = ser_load;
  assign fault_n_out = 1'b0;
  assign fault_oe_out = q.fault_oe;
  assign link_up_led_n_out = 1'b0;
  assign link_up_led_oe_out = q.led_oe;
  assign out_hiz_out = q.out_hiz;
  assign current_limit_en_out = q.cur_lim_en;
  assign out_level_code_out = q.vout_code;

endmodule

//--- verilog/wrx_pkg.sv
// Constants, field layout and types shared by the wireless receiver control logic.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
// Overview of operation
// - Shutdown input high forces shutdown, low runs
// - Charge done sends end packet, then shuts down
// - Output goes high impedance after that shutdown
// - Fault flag low on any fault source
// - Link indicator low only while link established
// - Packets ask raise, lower, hold or end
// - Packets leave at 2 kbps, decoded alike
// - Bits sent by grounding both coil nodes
// - Output level select grounded gives 5 V
// - Overcurrent select grounded disables current limit
// - Strength, identification, configuration precede power transfer
// - Control error packets repeat during transfer
package wrx_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int BIT_RATE_BPS = 2000;
  localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_BPS;

  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STRENGTH = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h5;

  // Control register fields
  localparam int CTRL_CMD_LSB = 0;
  localparam int CMD_W = 2;
  localparam int CTRL_STEP_LSB = 4;
  localparam int STEP_W = 4;
  localparam int CTRL_REASON_LSB = 8;

  // Status register fields
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_BUSY_BIT = 11;
  localparam int STAT_EPT_BIT = 12;
  localparam int STAT_FAULT_BIT = 13;

  // Interrupt bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_LINK = 1;
  localparam int IRQ_EPT = 2;
  localparam int IRQ_LOST = 3;
  localparam int IRQ_W = 4;

  // Synchronised pin vector
  localparam int PIN_EN_N = 0;
  localparam int PIN_DONE = 1;
  localparam int PIN_DIE_HOT = 2;
  localparam int PIN_TEMP_A = 3;
  localparam int PIN_TEMP_B = 4;
  localparam int PIN_PWR_OK = 5;
  localparam int PIN_OUT_LEVEL_SELECT_GND = 6;
  localparam int PIN_IOC_GND = 7;
  localparam int PIN_W = 8;

  // Output level codes: 4.50 V upward in 0.25 V steps
  localparam int VOUT_CODE_W = 3;
  localparam logic [VOUT_CODE_W-1:0] VOUT_CODE_5V = 3'h2;

  // Packets: header, payload, xor check byte
  localparam int PKT_BYTES = 3;
  localparam int PKT_W = PKT_BYTES * 8;
  localparam int FRAME_BITS = 11;
  localparam logic [7:0] HDR_STRENGTH = 8'h01;
  localparam logic [7:0] HDR_EPT = 8'h02;
  localparam logic [7:0] HDR_CTRL_ERR = 8'h03;
  localparam logic [7:0] HDR_CONFIG = 8'h51;
  localparam logic [7:0] HDR_IDENT = 8'h71;
  localparam logic [7:0] EPT_CHARGE_DONE = 8'h01;

  // Reset values
  localparam logic [STEP_W-1:0] STEP_RST = 4'h1;
  localparam logic [7:0] STRENGTH_RST = 8'h80;
  localparam logic [7:0] CONFIG_RST = 8'h00;

  typedef enum logic [CMD_W-1:0] {
    CMD_HOLD = 2'h0,
    CMD_UP = 2'h1,
    CMD_DOWN = 2'h2,
    CMD_END = 2'h3
  } power_cmd_t;

  // Gray codes along off, wait, handshake, transfer, end, done
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_WAIT = 3'h1,
    ST_SS = 3'h3,
    ST_ID = 3'h2,
    ST_CFG = 3'h6,
    ST_XFER = 3'h7,
    ST_EPT = 3'h5,
    ST_DONE = 3'h4
  } rx_state_t;

endpackage
